//--- sclk_ctrl.sv
// sclk_ctrl: system clock source select, pll relock gating, power modes
// assumes: config fields held by software, wake_irq from interrupt logic
`timescale 1ns/1ps
`default_nettype none
module sclk_ctrl #(
    parameter int NPERIPH = 32,
    parameter logic [12:0] RELOCK_COUNT = sclk_pkg::RELOCK_LOAD
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic main_osc_tick,
    input wire logic [3:0] crystal_select,
    input wire logic [1:0] rcc_osc_src,
    input wire logic rcc_bypass,
    input wire logic rcc_pll_pwrdn,
    input wire logic use_sys_divider,
    input wire logic [3:0] rcc_system_clock_divider,
    input wire logic auto_gating,
    input wire logic ext_config_select,
    input wire logic [2:0] ext_osc_src,
    input wire logic ext_bypass,
    input wire logic ext_pll_pwrdn,
    input wire logic [5:0] ext_system_clock_divider,
    input wire logic [2:0] deep_sleep_clock_config,
    input wire logic [NPERIPH-1:0] run_gating_regs,
    input wire logic [NPERIPH-1:0] sleep_gating_regs,
    input wire logic [NPERIPH-1:0] deep_sleep_gating_regs,
    input wire logic wait_for_interrupt,
    input wire logic deep_sleep_enable,
    input wire logic wake_irq,
    input wire logic pll_lock_int_mask,
    output sclk_pkg::sclk_src_e system_clock_sel_q,
    output logic [5:0] system_clock_divider_q,
    output logic use_sys_divider_q,
    output logic pll_power_q,
    output logic [13:0] pll_translation_q,
    output logic pll_lock_raw_status_q,
    output logic pll_lock_int_q,
    output logic [NPERIPH-1:0] periph_clk_en_q,
    output logic core_clk_en_q,
    output logic main_osc_power_q,
    output logic internal_osc_power_q,
    output logic low_osc_power_q,
    output logic sleep_q,
    output logic deep_sleep_q
);
    import sclk_pkg::*;

    sclk_mode_e mode_q, mode_d;
    sclk_src_e entry_src_q, entry_src_d;
    logic pll_was_q, pll_was_d;
    logic [3:0] crystal_select_q;
    logic bypass_eff, pwrdn_eff, crystal_select_chg, pll_up, relock_start;
    logic [5:0] div_eff;
    sclk_src_e osc_eff, src_run, ds_src;
    sclk_src_e sel_d;
    logic [5:0] div_d;
    logic use_div_d, pll_on_d, core_d, main_pwr_d, int_pwr_d, low_pwr_d;
    logic [NPERIPH-1:0] periph_d;
    logic [13:0] xlat_d;
    logic deep_d;

    sclk_relock_timer #(
        .CW(RELOCK_W),
        .LOAD(RELOCK_COUNT)
    ) u_relock (
        .clk(clk),
        .rst_b(rst_b),
        .start(relock_start),
        .tick(main_osc_tick),
        .pll_on(pll_power_q),
        .count_q(),
        .locked_q(pll_lock_raw_status_q)
    );

    // effective run configuration and relock triggers
    always_comb begin
        // computed first: a crystal change drops the pll before lock falls
        crystal_select_chg = crystal_select != crystal_select_q;
        bypass_eff = ext_config_select ? ext_bypass : rcc_bypass;
        pwrdn_eff = ext_config_select ? ext_pll_pwrdn : rcc_pll_pwrdn;
        div_eff = ext_config_select ? ext_system_clock_divider
                                    : {2'h0, rcc_system_clock_divider};
        if (ext_config_select) begin
            unique case (ext_osc_src)
                3'h1: osc_eff = SRC_INT;
                3'h2: osc_eff = SRC_INT4;
                3'h3: osc_eff = SRC_LOW;
                default: osc_eff = SRC_MAIN;
            endcase
        end else begin
            unique case (rcc_osc_src)
                2'h0: osc_eff = SRC_MAIN;
                2'h1: osc_eff = SRC_INT;
                2'h2: osc_eff = SRC_INT4;
                2'h3: osc_eff = SRC_LOW;
            endcase
        end
        // pll only once relocked, else the chosen oscillator
        if (!bypass_eff && pll_power_q && pll_lock_raw_status_q
                && !crystal_select_chg) begin
            src_run = SRC_PLL;
        end else begin
            src_run = osc_eff;
        end
        unique case (deep_sleep_clock_config)
            3'h1: ds_src = SRC_INT;
            3'h2: ds_src = SRC_INT4;
            3'h3: ds_src = SRC_LOW;
            default: ds_src = SRC_MAIN;
        endcase
        xlat_d = crystal_select_chg ? sclk_xlat(crystal_select)
                          : pll_translation_q;
    end

    // power mode sequencing
    always_comb begin
        mode_d = mode_q;
        entry_src_d = entry_src_q;
        pll_was_d = pll_was_q;
        unique case (mode_q)
            MD_RUN: begin
                if (wait_for_interrupt) begin
                    entry_src_d = src_run;
                    pll_was_d = pll_power_q;
                    mode_d = deep_sleep_enable ? MD_DEEP : MD_SLEEP;
                end
            end
            MD_SLEEP: begin
                if (wake_irq) begin
                    mode_d = MD_RUN;
                end
            end
            MD_DEEP: begin
                if (wake_irq) begin
                    mode_d = MD_WAKE;
                end
            end
            MD_WAKE: begin
                // stay until the entry source is back, then reopen clocks
                if (src_run == entry_src_q) begin
                    mode_d = MD_RUN;
                end
            end
            default: mode_d = MD_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= MD_RUN;
            entry_src_q <= SRC_INT;
            pll_was_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            entry_src_q <= entry_src_d;
            pll_was_q <= pll_was_d;
        end
    end

    // clock tree outputs, aligned with the next mode
    always_comb begin
        deep_d = mode_d == MD_DEEP;
        pll_on_d = !pwrdn_eff && !deep_d;
        pll_up = pll_on_d && !pll_power_q;
        relock_start = crystal_select_chg || pll_up;
        sel_d = deep_d ? ds_src : src_run;
        div_d = div_eff;
        use_div_d = use_sys_divider && !bypass_eff;
        if (deep_d && pll_was_d) begin
            div_d = ext_config_select ? DIV_DS_EXT : DIV_DS_BASE;
            use_div_d = 1'b1;
        end
        core_d = mode_d == MD_RUN;
        unique case (mode_d)
            MD_SLEEP: periph_d = auto_gating ? sleep_gating_regs
                                             : run_gating_regs;
            MD_DEEP, MD_WAKE: periph_d = auto_gating ? deep_sleep_gating_regs
                                                     : run_gating_regs;
            default: periph_d = run_gating_regs;
        endcase
        main_pwr_d = !(deep_d && ds_src != SRC_MAIN);
        int_pwr_d = !deep_d || ds_src == SRC_INT || ds_src == SRC_INT4;
        low_pwr_d = sel_d == SRC_LOW;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            system_clock_sel_q <= SRC_INT;
            system_clock_divider_q <= DIV_RST;
            use_sys_divider_q <= 1'b0;
            pll_power_q <= 1'b0;
            crystal_select_q <= CRYSTAL_SELECT_RST;
            pll_translation_q <= XLAT_RST;
            pll_lock_int_q <= 1'b0;
            periph_clk_en_q <= '0;
            core_clk_en_q <= 1'b1;
            main_osc_power_q <= 1'b1;
            internal_osc_power_q <= 1'b1;
            low_osc_power_q <= 1'b0;
            sleep_q <= 1'b0;
            deep_sleep_q <= 1'b0;
        end else begin
            system_clock_sel_q <= sel_d;
            system_clock_divider_q <= div_d;
            use_sys_divider_q <= use_div_d;
            pll_power_q <= pll_on_d;
            crystal_select_q <= crystal_select;
            pll_translation_q <= xlat_d;
            pll_lock_int_q <= pll_lock_raw_status_q && pll_lock_int_mask;
            periph_clk_en_q <= periph_d;
            core_clk_en_q <= core_d;
            main_osc_power_q <= main_pwr_d;
            internal_osc_power_q <= int_pwr_d;
            low_osc_power_q <= low_pwr_d;
            sleep_q <= mode_d == MD_SLEEP;
            deep_sleep_q <= deep_d || mode_d == MD_WAKE;
        end
    end

    a_pll_gated:
    assert property (@(posedge clk) disable iff (!rst_b)
        !pll_lock_raw_status_q |=> system_clock_sel_q != SRC_PLL)
    else $error("pll used as clock before relock");

    a_xlat_follow:
    assert property (@(posedge clk) disable iff (!rst_b)
        crystal_select_chg |=> pll_translation_q == sclk_xlat($past(crystal_select)))
    else $error("translation not updated on crystal change");

    a_same_crystal_select:
    assert property (@(posedge clk) disable iff (!rst_b)
        ($stable(crystal_select) && pll_power_q && $past(pll_power_q))
        |-> !relock_start)
    else $error("relock started without a change");

    a_pll_off_deep:
    assert property (@(posedge clk) disable iff (!rst_b)
        mode_q == MD_DEEP |-> !pll_power_q && (!pll_was_q ||
        system_clock_divider_q == DIV_DS_BASE || system_clock_divider_q == DIV_DS_EXT))
    else $error("deep sleep pll or divider override wrong");

    a_wfi_entry:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_RUN && wait_for_interrupt) |=>
        (deep_sleep_q == $past(deep_sleep_enable)) && !core_clk_en_q)
    else $error("wait for interrupt entered wrong mode");

    a_sleep_gating:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_SLEEP) |-> !core_clk_en_q && periph_clk_en_q ==
        $past(auto_gating ? sleep_gating_regs : run_gating_regs))
    else $error("sleep gating set not applied");

    a_deep_gating:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_DEEP) |-> periph_clk_en_q ==
        $past(auto_gating ? deep_sleep_gating_regs : run_gating_regs))
    else $error("deep sleep gating set not applied");

    a_sleep_wake:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_SLEEP && wake_irq) |=> core_clk_en_q && !sleep_q)
    else $error("interrupt did not wake from sleep");

    a_wake_order:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_WAKE) |-> !core_clk_en_q && deep_sleep_q
        && system_clock_sel_q == $past(src_run))
    else $error("clocks reopened before source restored");

    a_bypass_raw:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == MD_RUN && bypass_eff
        && !(wait_for_interrupt && deep_sleep_enable)) |=>
        !use_sys_divider_q && system_clock_sel_q != SRC_PLL)
    else $error("bypass did not run from raw oscillator");
endmodule : sclk_ctrl
`default_nettype wire

//--- sclk_pkg.sv
// sclk_pkg: constants and types shared by the system clock control block
// assumes: single 125 MHz control clock, plain configuration ports
package sclk_pkg;
    localparam int CLK_MHZ = 125;
    // clock sources offered to the system clock mux
    typedef enum logic [2:0] {
        SRC_MAIN = 3'h0,
        SRC_INT = 3'h1,
        SRC_INT4 = 3'h2,
        SRC_LOW = 3'h3,
        SRC_PLL = 3'h4
    } sclk_src_e;
    // power modes, one-hot
    typedef enum logic [3:0] {
        MD_RUN = 4'h1,
        MD_SLEEP = 4'h2,
        MD_DEEP = 4'h4,
        MD_WAKE = 4'h8
    } sclk_mode_e;
    localparam int RELOCK_W = 13;
    localparam logic [12:0] RELOCK_LOAD = 13'h1200;
    localparam logic [3:0] CRYSTAL_SELECT_RST = 4'hb;
    localparam logic [5:0] DIV_RST = 6'h0f;
    localparam logic [5:0] DIV_DS_BASE = 6'h0f;
    localparam logic [5:0] DIV_DS_EXT = 6'h3f;
    localparam logic [13:0] XLAT_BASE = 14'h0040;
    localparam logic [13:0] XLAT_STEP = 14'h0021;
    function automatic logic [13:0] sclk_xlat(input logic [3:0] x);
        return XLAT_BASE + 14'(14'(x) * XLAT_STEP);
    endfunction : sclk_xlat
    localparam logic [13:0] XLAT_RST = XLAT_BASE + 14'(14'(CRYSTAL_SELECT_RST) * XLAT_STEP);
endpackage : sclk_pkg

//--- sclk_relock_timer.sv
// sclk_relock_timer: pll relock down counter paced by main oscillator ticks
// assumes: tick is a one-cycle enable derived from the main oscillator
`timescale 1ns/1ps
`default_nettype none
module sclk_relock_timer #(
    parameter int CW = 13,
    parameter logic [CW-1:0] LOAD = '1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic tick,
    input wire logic pll_on,
    output logic [CW-1:0] count_q,
    output logic locked_q
);
    logic [CW-1:0] count_d;
    logic locked_d;

    always_comb begin
        count_d = count_q;
        if (start) begin
            count_d = LOAD;
        end else if (tick && pll_on && count_q != '0) begin
            count_d = count_q - CW'(1);
        end
        locked_d = pll_on && !start && count_d == '0;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= LOAD;
            locked_q <= 1'b0;
        end else begin
            count_q <= count_d;
            locked_q <= locked_d;
        end
    end

    a_relock_load:
    assert property (@(posedge clk) disable iff (!rst_b)
        start |=> count_q == LOAD)
    else $error("relock counter not loaded on start");

    a_lock_clear:
    assert property (@(posedge clk) disable iff (!rst_b)
        start |=> !locked_q ##0 (count_q != '0))
    else $error("lock shown during relock interval");

    a_lock_at_zero:
    assert property (@(posedge clk) disable iff (!rst_b)
        (count_q == CW'(1) && tick && pll_on && !start) |=> locked_q)
    else $error("lock not raised when counter expired");
endmodule : sclk_relock_timer
`default_nettype wire

//--- sclk_osc_model.sv
// sclk_osc_model: main oscillator stand-in giving one tick every PERIOD
// assumes: clk is the 125 MHz control clock, ticks start out of reset
`timescale 1ns/1ps
`default_nettype none
module sclk_osc_model #(
    parameter int PERIOD = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic main_osc_tick
);
    logic [7:0] cnt_q;
    // oscillator runs from reset release, so the reference is stable for the pll
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            main_osc_tick <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
            main_osc_tick <= (cnt_q == 8'(PERIOD - 1));
        end
    end
endmodule : sclk_osc_model
`default_nettype wire

//--- tb.sv
// tb: self-checking bench for sclk_ctrl with a main oscillator model
// assumes: sclk_pkg and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sclk_pkg::*;
    localparam int NP = 8;
    localparam int TP = 4;
    localparam logic [12:0] RC = 13'h0010;
    typedef struct packed {
        logic [1:0] src; logic esel; logic [2:0] esrc;
        logic byp; logic ebyp; sclk_src_e sel; logic use_div;
    } sclk_row_s;
    localparam sclk_row_s ROWS [8] = '{
        '{2'h0, 1'h0, 3'h0, 1'h1, 1'h0, SRC_MAIN, 1'h0},
        '{2'h1, 1'h0, 3'h0, 1'h0, 1'h0, SRC_INT, 1'h1},
        '{2'h2, 1'h0, 3'h0, 1'h1, 1'h0, SRC_INT4, 1'h0},
        '{2'h3, 1'h0, 3'h0, 1'h0, 1'h0, SRC_LOW, 1'h1},
        '{2'h1, 1'h1, 3'h0, 1'h0, 1'h1, SRC_MAIN, 1'h0},
        '{2'h0, 1'h1, 3'h1, 1'h1, 1'h0, SRC_INT, 1'h1},
        '{2'h0, 1'h1, 3'h2, 1'h0, 1'h0, SRC_INT4, 1'h1},
        '{2'h0, 1'h1, 3'h3, 1'h0, 1'h1, SRC_LOW, 1'h0}};
    logic clk, rst_b, tick, base_byp, base_pd, use_div, ag, esel, ebyp;
    logic epd, sleep_req, deep_en, wake, mask, use_q, pwr, lock, intq;
    logic core, mpwr, ipwr, lpwr, slp, dslp;
    logic [3:0] crys, base_div;
    logic [1:0] base_src;
    logic [2:0] esrc, ds_cfg;
    logic [5:0] ediv, div;
    logic [13:0] xl;
    logic [NP-1:0] rg, sg, dg, pen;
    sclk_src_e sel;
    int errors, n_checks, n;
    sclk_osc_model #(.PERIOD(TP)) osc (.clk(clk), .rst_b(rst_b),
        .main_osc_tick(tick));
    sclk_ctrl #(.NPERIPH(NP), .RELOCK_COUNT(RC)) dut (
        .clk(clk), .rst_b(rst_b), .main_osc_tick(tick),
        .crystal_select(crys), .rcc_osc_src(base_src),
        .rcc_bypass(base_byp), .rcc_pll_pwrdn(base_pd),
        .use_sys_divider(use_div), .rcc_system_clock_divider(base_div),
        .auto_gating(ag), .ext_config_select(esel), .ext_osc_src(esrc),
        .ext_bypass(ebyp), .ext_pll_pwrdn(epd), .ext_system_clock_divider(ediv),
        .deep_sleep_clock_config(ds_cfg), .run_gating_regs(rg),
        .sleep_gating_regs(sg), .deep_sleep_gating_regs(dg),
        .wait_for_interrupt(sleep_req), .deep_sleep_enable(deep_en),
        .wake_irq(wake), .pll_lock_int_mask(mask),
        .system_clock_sel_q(sel), .system_clock_divider_q(div),
        .use_sys_divider_q(use_q), .pll_power_q(pwr),
        .pll_translation_q(xl), .pll_lock_raw_status_q(lock),
        .pll_lock_int_q(intq), .periph_clk_en_q(pen), .core_clk_en_q(core),
        .main_osc_power_q(mpwr), .internal_osc_power_q(ipwr),
        .low_osc_power_q(lpwr), .sleep_q(slp), .deep_sleep_q(dslp));
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle
    // one-cycle request, lowered on the next edge
    task automatic pulse(input bit to_sleep);
        @(posedge clk);
        if (to_sleep) begin
            sleep_req <= 1'b1;
        end else begin
            wake <= 1'b1;
        end
        @(posedge clk);
        sleep_req <= 1'b0;
        wake <= 1'b0;
        settle();
    endtask : pulse
    // pll must stay off the clock until the relock count has run out
    task automatic pll_wait();
        n = 0;
        while (lock !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
            if (sel === SRC_PLL) check("early pll", 1, 0);
        end
        check("relock span", n >= (int'(RC) - 1) * TP, 1);
        check("relock end", n <= (int'(RC) + 1) * TP + 4, 1);
    endtask : pll_wait
    // deep sleep exit: wait for the core clock to come back
    task automatic wake_wait();
        n = 0;
        while (core !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("wake core", core, 1);
    endtask : wake_wait
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 6000);
        errors++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0; crys = 4'hb; base_src = 2'h1; base_byp = 1'b1;
        base_pd = 1'b1; use_div = 1'b1; base_div = 4'h3; ag = 1'b0;
        esel = 1'b0; esrc = 3'h0; ebyp = 1'b0; epd = 1'b1; ediv = 6'h2a;
        ds_cfg = 3'h1; rg = 8'h3c; sg = 8'h0f; dg = 8'hc1;
        sleep_req = 1'b0; deep_en = 1'b0; wake = 1'b0; mask = 1'b1;
        repeat (8) @(negedge clk);
        check("reset source", sel, SRC_INT);
        check("reset pll", pwr, 0);
        check("reset xlat", xl, XLAT_BASE + 14'h000b * XLAT_STEP);
        check("reset core", core, 1);
        @(posedge clk);
        rst_b <= 1'b1;
        settle();
        check("post reset source", sel, SRC_INT);
        check("post reset pll", pwr, 0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            @(posedge clk);
            esel <= ROWS[i].esel;
            base_src <= ROWS[i].src; esrc <= ROWS[i].esrc;
            base_byp <= ROWS[i].byp; ebyp <= ROWS[i].ebyp;
            settle();
            check("source", sel, ROWS[i].sel);
            check("divider use", use_q, ROWS[i].use_div);
            if (ROWS[i].esel) check("ext divider", div, 6'h2a);
            else check("base divider", div, 6'h03);
            check("low osc power", lpwr, ROWS[i].sel == SRC_LOW);
            check("run gating", pen, rg);
        end
        $display("test source table done");
        @(posedge clk);
        crys <= 4'h6; esel <= 1'b0; base_src <= 2'h0;
        settle();
        check("xlat", xl, XLAT_BASE + 14'h0006 * XLAT_STEP);
        @(posedge clk);
        base_byp <= 1'b0; base_pd <= 1'b0;
        settle();
        check("pll on", pwr, 1);
        check("stay osc", sel, SRC_MAIN);
        check("lock low", lock, 0);
        pll_wait();
        repeat (2) @(negedge clk);
        check("to pll", sel, SRC_PLL);
        check("lock int", intq, 1);
        @(posedge clk);
        mask <= 1'b0;
        settle();
        check("lock masked", intq, 0);
        @(posedge clk);
        crys <= 4'h6;
        repeat (6) @(negedge clk);
        check("same crystal", lock, 1);
        @(posedge clk);
        crys <= 4'h5;
        settle();
        check("relock", lock, 0);
        check("off pll", sel === SRC_PLL, 0);
        check("xlat new", xl, XLAT_BASE + 14'h0005 * XLAT_STEP);
        pll_wait();
        repeat (2) @(negedge clk);
        $display("test pll relock done");
        for (int a = 0; a < 2; a++) begin
            @(posedge clk);
            ag <= 1'(a);
            deep_en <= 1'b0;
            pulse(1'b1);
            check("sleep", slp, 1);
            check("sleep core", core, 0);
            check("sleep source", sel, SRC_PLL);
            check("sleep gating", pen, a ? sg : rg);
            pulse(1'b0);
            check("wake", {slp, core}, 2'h1);
            check("wake gating", pen, rg);
        end
        $display("test sleep done");
        @(posedge clk);
        deep_en <= 1'b1;
        pulse(1'b1);
        check("deep", {dslp, core}, 2'h2);
        check("deep source", sel, SRC_INT);
        check("deep osc", {mpwr, ipwr}, 2'h1);
        check("deep pll", pwr, 0);
        check("deep divider", div, 6'h0f);
        check("deep gating", pen, dg);
        pulse(1'b0);
        wake_wait();
        check("restored source", sel, SRC_PLL);
        check("restored gating", pen, rg);
        check("deep left", dslp, 0);
        check("restored divider", div, 6'h03);
        check("restored osc", {mpwr, ipwr}, 2'h3);
        @(posedge clk);
        esel <= 1'b1; esrc <= 3'h0; ebyp <= 1'b0; epd <= 1'b0;
        pulse(1'b1);
        check("deep ext divider", div, 6'h3f);
        pulse(1'b0);
        wake_wait();
        check("ext restored", {sel, div}, {SRC_PLL, 6'h2a});
        $display("test deep sleep done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
